// File: hw/prt_pkg.sv
// Shared constants for the inrush and thermal protection sequencer.
package prt_pkg;
  // Channel count and system clock rate.
  localparam int NUM_CH = 4;
  localparam int CLK_KHZ = 50000;
  localparam int CNT_W = 22;

  // Inrush window lengths in milliseconds, regular and halved, then the auto-restart delay.
  localparam real WIN1_MS = 2.0;
  localparam real WIN1_HALF_MS = 1.0;
  localparam real WIN2_MS = 8.0;
  localparam real WIN2_HALF_MS = 4.0;
  localparam real WIN3_MS = 64.0;
  localparam real WIN3_HALF_MS = 32.0;
  localparam real AUTORESTART_MS = 64.0;

  // Deglitch and wake-up blanking in microseconds.
  localparam real FILTER_US = 2.0;
  localparam real FILTER_MAX_US = 3.0;
  localparam real BLANK_US = 50.0;
  localparam real BLANK_MAX_US = 100.0;

  // Cycle counts; nominal figures land on whole cycles at 50 MHz.
  localparam int WIN1_CYC = $rtoi(WIN1_MS * CLK_KHZ);
  localparam int WIN1_HALF_CYC = $rtoi(WIN1_HALF_MS * CLK_KHZ);
  localparam int WIN2_CYC = $rtoi(WIN2_MS * CLK_KHZ);
  localparam int WIN2_HALF_CYC = $rtoi(WIN2_HALF_MS * CLK_KHZ);
  localparam int WIN3_CYC = $rtoi(WIN3_MS * CLK_KHZ);
  localparam int WIN3_HALF_CYC = $rtoi(WIN3_HALF_MS * CLK_KHZ);
  localparam int AUTORESTART_CYC = $rtoi(AUTORESTART_MS * CLK_KHZ);
  localparam int FILTER_CYC = $rtoi(FILTER_US * CLK_KHZ / 1000.0);
  localparam int FILTER_MAX_CYC = $rtoi(FILTER_MAX_US * CLK_KHZ / 1000.0);
  localparam int BLANK_CYC = $rtoi(BLANK_US * CLK_KHZ / 1000.0);
  localparam int BLANK_MAX_CYC = $rtoi(BLANK_MAX_US * CLK_KHZ / 1000.0);
  localparam int BLANK_W = 12;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CHANNEL = 8'h04;
  localparam logic [7:0] ADDR_QUICK = 8'h08;
  localparam logic [7:0] ADDR_CH_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_CH_STATUS_LAST = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

  // Configuration register fields and reset value.
  localparam int CFG_THERMAL = 0;
  localparam int CFG_TRANSIENT = 1;
  localparam int CFG_WARN_SEL = 2;
  localparam int CFG_FAIL = 3;
  localparam int CFG_PWM = 4;
  localparam int CFG_W = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

  // Channel control fields: on bits low nibble, halved-window bits next.
  localparam int CTRL_ON_LSB = 0;
  localparam int CTRL_HALF_LSB = 4;

  // Quick status and interrupt layout: overcurrent, shutdown, warning nibbles.
  localparam int EV_OC_LSB = 0;
  localparam int EV_SHUT_LSB = 4;
  localparam int EV_WARN_LSB = 8;
  localparam int QS_OUT_LSB = 12;
  localparam int EV_W = 12;

  // Per-channel status fields.
  localparam int CS_WARN = 0;
  localparam int CS_SHUT = 1;
  localparam int CS_OC = 2;
  localparam int CS_LATCH = 3;
  localparam int CS_STAGE_LSB = 4;
  localparam int CS_OUT = 6;
  localparam int CS_HALF = 7;
endpackage

// File: hw/prt_filter.sv
// Two-flop synchroniser followed by a per-bit deglitch filter.
`timescale 1ns/1ps
module prt_filter #(
  parameter int WIDTH = 1,
  parameter int DG_CYC = 100
) (
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic blank, // Holds every filtered output low.
  input wire logic [WIDTH-1:0] raw, // Asynchronous flags.
  output logic [WIDTH-1:0] clean // Filtered flags.
);
  localparam int CW = $clog2(DG_CYC + 1);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] q;
    logic [WIDTH-1:0][CW-1:0] cnt;
  } prt_flt_t;

  prt_flt_t st;
  prt_flt_t next_st;

  // A change must hold for DG_CYC cycles before it passes; s1 feeds only s2.
  always_comb begin
    next_st = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    for (int i = 0; i < WIDTH; i++) begin
      if (blank) begin
        next_st.q[i] = 1'b0;
        next_st.cnt[i] = '0;
      end else if (st.s2[i] == st.q[i]) begin
        next_st.cnt[i] = '0;
      end else if (st.cnt[i] == CW'(DG_CYC - 1)) begin
        next_st.q[i] = st.s2[i];
        next_st.cnt[i] = '0;
      end else begin
        next_st.cnt[i] = st.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clean = st.q;
endmodule

// File: hw/prt_window.sv
// Three-stage inrush window timer for one channel.
`timescale 1ns/1ps
module prt_window #(
  parameter int CNT_W = 22,
  parameter int W1 = 100000,
  parameter int W1H = 50000,
  parameter int W2 = 400000,
  parameter int W2H = 200000,
  parameter int W3 = 3200000,
  parameter int W3H = 1600000
) (
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic start, // Restarts the full window sequence.
  input wire logic run, // Counting advances only while high.
  input wire logic halved, // Selects half-length windows.
  output logic [1:0] stage, // 1..3 inrush level, 0 steady limit.
  output logic active // High while a window is open.
);
  typedef enum logic [2:0] {WIN_IDLE, WIN_ONE, WIN_TWO, WIN_THREE, WIN_STEADY} prt_win_state_t;

  typedef struct packed {
    prt_win_state_t state;
    logic [CNT_W-1:0] cnt;
  } prt_win_t;

  prt_win_t st;
  prt_win_t next_st;
  logic [CNT_W-1:0] lim;

  // Each window ends on its last cycle; the count freezes while run is low.
  always_comb begin
    next_st = st;
    case (st.state)
      WIN_ONE: lim = halved ? CNT_W'(W1H - 1) : CNT_W'(W1 - 1);
      WIN_TWO: lim = halved ? CNT_W'(W2H - 1) : CNT_W'(W2 - 1);
      default: lim = halved ? CNT_W'(W3H - 1) : CNT_W'(W3 - 1);
    endcase
    if (start) begin
      next_st.state = WIN_ONE;
      next_st.cnt = '0;
    end else if (run && active) begin
      if (st.cnt >= lim) begin
        next_st.cnt = '0;
        case (st.state)
          WIN_ONE: next_st.state = WIN_TWO;
          WIN_TWO: next_st.state = WIN_THREE;
          default: next_st.state = WIN_STEADY;
        endcase
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '{state: WIN_IDLE, cnt: '0};
    end else begin
      st <= next_st;
    end
  end

  // Stage encoding drives the threshold select of the analog comparator.
  always_comb begin
    active = (st.state == WIN_ONE) || (st.state == WIN_TWO) || (st.state == WIN_THREE);
    case (st.state)
      WIN_ONE: stage = 2'h1;
      WIN_TWO: stage = 2'h2;
      WIN_THREE: stage = 2'h3;
      default: stage = 2'h0;
    endcase
  end
endmodule

// File: hw/prt_sequencer.sv
// Per-channel protection sequencer with an AHB-Lite register slave.
// What this block does
// - Thermal enable plus hot die selects the reduced first inrush level.
// - Transient enable halves thresholds while output is below half supply at turn-on.
// - First window is 2.0 ms, or 1.0 ms when halved.
// - Second window is 8.0 ms, or 4.0 ms when halved.
// - Third window is 64 ms, or 32 ms when halved.
// - Overcurrent and severe-short detections pass a 2.0 us deglitch filter.
// - In fail mode a restartable fault re-enables the output after 64 ms.
// - Fault detections are ignored for 50 us after wake-up.
// - Each channel has warning and shutdown temperature stages.
// - Filtered shutdown temperature turns the output off and sets shutdown status.
// - A warning leaves the output alone and sets quick and channel status.
// - Warning select 0 picks the higher threshold, 1 the lower one.
// - Warning clears only when temperature is low and channel status is read.
// - Per-channel halved-window bit resets to 0 and halves all windows.
// - In pulse-width mode window counting pauses while channel control is low.
// - Off then on restarts the windows; rewriting on while on does not.
`timescale 1ns/1ps
module prt_sequencer
  import prt_pkg::*;
#(
  parameter int WIN1_N = prt_pkg::WIN1_CYC,
  parameter int WIN1H_N = prt_pkg::WIN1_HALF_CYC,
  parameter int WIN2_N = prt_pkg::WIN2_CYC,
  parameter int WIN2H_N = prt_pkg::WIN2_HALF_CYC,
  parameter int WIN3_N = prt_pkg::WIN3_CYC,
  parameter int WIN3H_N = prt_pkg::WIN3_HALF_CYC,
  parameter int AUTO_N = prt_pkg::AUTORESTART_CYC
) (
  input wire logic hclk, // System clock, 50 MHz.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // High for a write.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic [31:0] hrdata, // Read data.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Always OKAY.
  output logic irq, // Level interrupt.
  input wire logic wake_up, // Wake-up pulse, starts blanking.
  input wire logic [prt_pkg::NUM_CH-1:0] pwm_in, // Pulse-width inputs.
  input wire logic [prt_pkg::NUM_CH-1:0] oc_trip, // Comparator over selected level.
  input wire logic [prt_pkg::NUM_CH-1:0] severe_short_detect, // Severe short flag.
  input wire logic [prt_pkg::NUM_CH-1:0] temperature_shutdown, // Shutdown temperature.
  input wire logic [prt_pkg::NUM_CH-1:0] temperature_warning_high, // Higher warning level.
  input wire logic [prt_pkg::NUM_CH-1:0] temperature_warning_low, // Lower warning level.
  input wire logic die_hot, // Die above reduction threshold.
  input wire logic [prt_pkg::NUM_CH-1:0] vout_half, // Output at or above half supply.
  output logic [prt_pkg::NUM_CH-1:0] out_enable, // Power switch gate enable.
  output logic [2*prt_pkg::NUM_CH-1:0] inrush_stage, // Two bits per channel.
  output logic [prt_pkg::NUM_CH-1:0] half_scale, // Half-scale thresholds.
  output logic level_one_reduced // Reduced first inrush level.
);
  import prt_pkg::*;

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [NUM_CH-1:0] on;
    logic [NUM_CH-1:0] halved;
    logic [NUM_CH-1:0] on_q;
    logic [NUM_CH-1:0] oc;
    logic [NUM_CH-1:0] latch;
    logic [NUM_CH-1:0] shut;
    logic [NUM_CH-1:0] warn;
    logic [NUM_CH-1:0][CNT_W-1:0] restart;
    logic [BLANK_W-1:0] blank;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic [NUM_CH-1:0] out_en;
    logic [NUM_CH-1:0] half;
    logic reduced;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic rd_done;
    logic [31:0] rdata;
  } prt_state_t;

  prt_state_t st;
  prt_state_t next_st;

  logic [NUM_CH-1:0] oc_f;
  logic [NUM_CH-1:0] ssc_f;
  logic [NUM_CH-1:0] tsh_f;
  logic [NUM_CH-1:0] whi_f;
  logic [NUM_CH-1:0] wlo_f;
  logic [NUM_CH-1:0] vhalf_s;
  logic hot_s;
  logic blanking;
  logic [NUM_CH-1:0] channel_output_control;
  logic [NUM_CH-1:0] blocked;
  logic [NUM_CH-1:0] on_eff;
  logic [NUM_CH-1:0] win_start;
  logic [NUM_CH-1:0] win_active;
  logic [NUM_CH-1:0][1:0] stage;
  logic [NUM_CH-1:0] warn_now;
  logic [EV_W-1:0] events;
  logic accept;
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_val;
  logic [1:0] ch_idx;

  // Fault flags are blanked after wake-up and deglitched before use.
  assign blanking = (st.blank != '0);
  prt_filter #(.WIDTH(5 * NUM_CH), .DG_CYC(FILTER_CYC)) u_fault_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .blank(blanking),
    .raw({oc_trip, severe_short_detect, temperature_shutdown, temperature_warning_high, temperature_warning_low}),
    .clean({oc_f, ssc_f, tsh_f, whi_f, wlo_f})
  );

  // Supply and die flags only need synchronising, so one stable cycle passes them.
  prt_filter #(.WIDTH(NUM_CH + 1), .DG_CYC(1)) u_level_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .blank(1'h0),
    .raw({vout_half, die_hot}),
    .clean({vhalf_s, hot_s})
  );

  // Channel control follows the on bit, gated by the pulse input in pulse-width mode.
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      channel_output_control[c] = st.on[c] & (st.cfg[CFG_PWM] ? pwm_in[c] : 1'b1);
      blocked[c] = st.latch[c] | (st.restart[c] != '0);
      on_eff[c] = st.on[c] & ~blocked[c];
      win_start[c] = on_eff[c] & ~st.on_q[c];
      warn_now[c] = st.cfg[CFG_WARN_SEL] ? wlo_f[c] : whi_f[c];
    end
  end

  // One window timer per channel; pauses while channel control is low.
  for (genvar g = 0; g < NUM_CH; g++) begin : g_win
    prt_window #(
      .CNT_W(CNT_W),
      .W1(WIN1_N),
      .W1H(WIN1H_N),
      .W2(WIN2_N),
      .W2H(WIN2H_N),
      .W3(WIN3_N),
      .W3H(WIN3H_N)
    ) u_window (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(win_start[g]),
      .run(on_eff[g] & channel_output_control[g]),
      .halved(st.halved[g]),
      .stage(stage[g]),
      .active(win_active[g])
    );
  end

  // Bus decode: word reads take one wait state so that read data leave a flip-flop.
  assign accept = hsel & hready & htrans[1];
  assign wr_go = st.dp_valid & st.dp_write;
  assign rd_go = st.dp_valid & ~st.dp_write & ~st.rd_done;
  assign ch_idx = 2'((st.dp_addr - ADDR_CH_STATUS) >> 2);

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_val = 32'h0000_0000;
    if (st.dp_addr == ADDR_CONFIG) begin
      rd_val[CFG_W-1:0] = st.cfg;
    end else if (st.dp_addr == ADDR_CHANNEL) begin
      rd_val[CTRL_ON_LSB +: NUM_CH] = st.on;
      rd_val[CTRL_HALF_LSB +: NUM_CH] = st.halved;
    end else if (st.dp_addr == ADDR_QUICK) begin
      rd_val[EV_OC_LSB +: NUM_CH] = st.oc;
      rd_val[EV_SHUT_LSB +: NUM_CH] = st.shut;
      rd_val[EV_WARN_LSB +: NUM_CH] = st.warn;
      rd_val[QS_OUT_LSB +: NUM_CH] = st.out_en;
    end else if (st.dp_addr >= ADDR_CH_STATUS && st.dp_addr <= ADDR_CH_STATUS_LAST && st.dp_addr[1:0] == 2'h0) begin
      rd_val[CS_WARN] = st.warn[ch_idx];
      rd_val[CS_SHUT] = st.shut[ch_idx];
      rd_val[CS_OC] = st.oc[ch_idx];
      rd_val[CS_LATCH] = st.latch[ch_idx];
      rd_val[CS_STAGE_LSB +: 2] = stage[ch_idx];
      rd_val[CS_OUT] = st.out_en[ch_idx];
      rd_val[CS_HALF] = st.half[ch_idx];
    end else if (st.dp_addr == ADDR_IRQ_STATUS) begin
      rd_val[EV_W-1:0] = st.irq_stat;
    end else if (st.dp_addr == ADDR_IRQ_MASK) begin
      rd_val[EV_W-1:0] = st.irq_mask;
    end
  end

  // Next-state logic: bus, protection and interrupts in one place.
  always_comb begin
    next_st = st;
    events = '0;

    // Bus phases.
    if (hreadyout) begin
      next_st.dp_valid = accept;
      next_st.dp_write = hwrite;
      next_st.dp_addr = haddr[7:0];
      next_st.rd_done = 1'b0;
    end else begin
      next_st.rd_done = 1'b1;
    end
    if (rd_go) begin
      next_st.rdata = rd_val;
    end

    // Blanking restarts on every wake-up.
    if (wake_up) begin
      next_st.blank = BLANK_W'(BLANK_CYC);
    end else if (blanking) begin
      next_st.blank = st.blank - 1'b1;
    end

    // Register writes; writing on clears a latched fault unless the filtered shutdown temperature persists.
    if (wr_go) begin
      if (st.dp_addr == ADDR_CONFIG) begin
        next_st.cfg = hwdata[CFG_W-1:0];
      end else if (st.dp_addr == ADDR_CHANNEL) begin
        next_st.on = hwdata[CTRL_ON_LSB +: NUM_CH];
        next_st.halved = hwdata[CTRL_HALF_LSB +: NUM_CH];
        for (int c = 0; c < NUM_CH; c++) begin
          if (hwdata[CTRL_ON_LSB + c] && !tsh_f[c]) begin
            next_st.latch[c] = 1'b0;
          end
        end
      end else if (st.dp_addr == ADDR_IRQ_STATUS) begin
        next_st.irq_stat = st.irq_stat & ~hwdata[EV_W-1:0];
      end else if (st.dp_addr == ADDR_IRQ_MASK) begin
        next_st.irq_mask = hwdata[EV_W-1:0];
      end
    end

    // Reading a channel status releases the flags whose conditions are gone.
    if (rd_go && st.dp_addr >= ADDR_CH_STATUS && st.dp_addr <= ADDR_CH_STATUS_LAST && st.dp_addr[1:0] == 2'h0) begin
      if (!warn_now[ch_idx]) begin
        next_st.warn[ch_idx] = 1'b0;
      end
      if (!tsh_f[ch_idx]) begin
        next_st.shut[ch_idx] = 1'b0;
      end
      next_st.oc[ch_idx] = 1'b0;
    end

    // Protection per channel; every set below overrides the clears above.
    for (int c = 0; c < NUM_CH; c++) begin
      next_st.on_q[c] = on_eff[c];
      // Warning only reports; the output keeps its state.
      if (warn_now[c]) begin
        next_st.warn[c] = 1'b1;
        events[EV_WARN_LSB + c] = ~st.warn[c];
      end
      // Filtered shutdown temperature switches off and reports together.
      if (tsh_f[c]) begin
        next_st.shut[c] = 1'b1;
        next_st.latch[c] = 1'b1;
        events[EV_SHUT_LSB + c] = ~st.shut[c];
      end
      // Overcurrent: first level and severe short latch; others restart in fail mode.
      if (on_eff[c] && (oc_f[c] || ssc_f[c])) begin
        next_st.oc[c] = 1'b1;
        events[EV_OC_LSB + c] = 1'b1;
        if (st.cfg[CFG_FAIL] && !ssc_f[c] && stage[c] != 2'h1) begin
          next_st.restart[c] = CNT_W'(AUTO_N);
        end else begin
          next_st.latch[c] = 1'b1;
        end
      end else if (st.restart[c] != '0) begin
        next_st.restart[c] = st.restart[c] - 1'b1;
      end
      next_st.out_en[c] = channel_output_control[c] & ~next_st.latch[c] & (next_st.restart[c] == '0);
      // Half-scale thresholds only during turn-on below half supply.
      next_st.half[c] = st.cfg[CFG_TRANSIENT] & win_active[c] & channel_output_control[c] & ~vhalf_s[c];
    end

    // Reduced first level when enabled and the die is hot.
    next_st.reduced = st.cfg[CFG_THERMAL] & hot_s;

    // Sticky interrupt bits: a new event wins over a same-cycle clear.
    next_st.irq_stat = next_st.irq_stat | events;
  end

  // State register; blanking is armed from reset as after a wake-up.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.cfg <= CFG_RESET;
      st.blank <= BLANK_W'(BLANK_CYC);
    end else begin
      st <= next_st;
    end
  end

  // Outputs.
  assign hreadyout = ~(st.dp_valid & ~st.dp_write & ~st.rd_done);
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign irq = |(st.irq_stat & st.irq_mask);
  assign out_enable = st.out_en;
  assign half_scale = st.half;
  assign level_one_reduced = st.reduced;
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      inrush_stage[2*c +: 2] = stage[c];
    end
  end
endmodule

// File: bench/prt_sequencer_asserts.sv
// Port checker for the protection sequencer.
`timescale 1ns/1ps
module prt_seq_asserts(
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset.
  input wire logic hsel, // Select.
  input wire logic [1:0] htrans, // Type.
  input wire logic hwrite, // Write.
  input wire logic hready, // Ready.
  input wire logic hreadyout, // Slave ready.
  input wire logic hresp, // Response.
  input wire logic irq, // Interrupt.
  input wire logic wake_up, // Wake.
  input wire logic die_hot, // Hot die.
  input wire logic [3:0] vout_half, // Half supply.
  input wire logic [7:0] inrush_stage, // Stages.
  input wire logic [3:0] half_scale, // Half scale.
  input wire logic level_one_reduced // Reduced.
);
  logic [11:0] bcnt;
  logic [1:0] st;
  logic s1, s2, vh0, acc;
  assign st = inrush_stage[1:0];
  assign s1 = st == 2'h1;
  assign s2 = st == 2'h2;
  assign vh0 = vout_half[0];
  assign acc = hsel && hready && htrans[1];
  // Cycles since reset or wake-up; saturates so it cannot wrap.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcnt <= 12'h000;
    end else if (wake_up) begin
      bcnt <= 12'h000;
    end else if (bcnt != 12'hfff) begin
      bcnt <= bcnt + 12'h001;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rd; acc && !hwrite |=> s_wait; endproperty
  a_rd: assert property (p_rd) else $error("read wait wrong");
  property p_wr; acc && hwrite |=> hreadyout; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_thr; level_one_reduced |-> $past(die_hot, 4); endproperty
  a_thr: assert property (p_thr) else $error("reduced level on cool die");
  property p_half; half_scale[0] |-> !$past(vh0, 4); endproperty
  a_half: assert property (p_half) else $error("half scale above half supply");
  property p_step; st != $past(st) |-> st == $past(st) + 2'h1 || st == 2'h1; endproperty
  a_step: assert property (p_step) else $error("stage skipped");
  property p_w1; s2 && $past(s1) |-> $past(s1, 10); endproperty
  a_w1: assert property (p_w1) else $error("first window short");
  property p_w2; st == 2'h3 && $past(s2) |-> $past(s2, 20); endproperty
  a_w2: assert property (p_w2) else $error("second window short");
  property p_blank; bcnt < 12'h9c4 |-> !irq; endproperty
  a_blank: assert property (p_blank) else $error("event during blanking");
endmodule

// File: bench/prt_stage_model.sv
// Analog power stage model: current, voltage and temperature flags.
`timescale 1ns/1ps
module prt_stage_model(
  input wire logic hclk, // Clock.
  input wire logic [3:0] out_enable, // Gates.
  input wire logic level_one_reduced, // Reduced.
  input wire logic [3:0] half_scale, // Half scale.
  input wire logic [7:0] load_a, // Load amperes.
  input wire logic [31:0] temp_c, // Byte per channel.
  input wire logic [7:0] die_c, // Die degrees.
  output logic [3:0] oc_trip, // Over level.
  output logic [3:0] temperature_shutdown, // Shutdown.
  output logic [3:0] temperature_warning_high, // High warn.
  output logic [3:0] temperature_warning_low, // Low warn.
  output logic die_hot, // Hot die.
  output logic [3:0] vout_half // Half supply.
);
  logic [7:0] lim;
  logic [7:0] t;
  // Current flows only through an open gate, so a closed channel never trips.
  always_comb begin
    lim = 8'h64;
    t = 8'h00;
    die_hot = die_c > 8'h3f;
    for (int c = 0; c < 4; c++) begin
      t = temp_c[8*c +: 8];
      lim = half_scale[c] ? 8'h32 : (level_one_reduced ? 8'h55 : 8'h64);
      oc_trip[c] = out_enable[c] && load_a > lim;
      temperature_shutdown[c] = t >= 8'haa;
      temperature_warning_high[c] = t >= 8'h87;
      temperature_warning_low[c] = t >= 8'h73;
    end
  end
  // Output voltage trails the gate by a cycle.
  always_ff @(posedge hclk) begin
    vout_half <= out_enable;
  end
endmodule

// File: bench/prt_sequencer_tb_top.sv
// Self-checking bench for the protection sequencer.
`timescale 1ns/1ps
module prt_sequencer_tb_top;
  import prt_pkg::*;
  localparam int WS = 140;
  logic hclk, hresetn, hsel, hwrite, wake_up, hreadyout, hresp, irq, ldr, dh;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, temp_c;
  logic [3:0] pwm_in, ssd, ts, twh, twl, vh, oc, oe, hs;
  logic [7:0] stg, load_a, die_c;
  wire hready = hreadyout;
  int num_errors, n_checks, cyc, n0, n1;
  prt_sequencer #(.WIN1_N(20), .WIN1H_N(10), .WIN2_N(40), .WIN2H_N(20), .WIN3_N(80), .WIN3H_N(40),
    .AUTO_N(150)) dut(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hresp(hresp),
    .hreadyout(hreadyout), .irq(irq), .wake_up(wake_up), .pwm_in(pwm_in), .oc_trip(oc),
    .severe_short_detect(ssd), .temperature_shutdown(ts), .temperature_warning_high(twh),
    .temperature_warning_low(twl), .die_hot(dh), .vout_half(vh), .out_enable(oe),
    .inrush_stage(stg), .half_scale(hs), .level_one_reduced(ldr));
  prt_stage_model model(.hclk(hclk), .out_enable(oe), .level_one_reduced(ldr), .half_scale(hs),
    .load_a(load_a), .temp_c(temp_c), .die_c(die_c), .oc_trip(oc), .temperature_shutdown(ts),
    .temperature_warning_high(twh), .temperature_warning_low(twl), .die_hot(dh), .vout_half(vh));
  // Free-running 50 MHz clock.
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // A hang ends the run long after the sequence should be over.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single AHB-Lite word transfer; read data lands in rd.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (!hready);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hready);
    rd = hrdata;
  endtask
  // Turns two channels on, rewrites the on bits mid-window, counts window cycles.
  task automatic win_run();
    bus(1'b1, ADDR_CHANNEL, 32'h0000_0023);
    fork
      begin
        repeat (8) @(posedge hclk);
        bus(1'b1, ADDR_CHANNEL, 32'h0000_0023);
      end
    join_none
    n0 = 0;
    n1 = 0;
    repeat (200) begin
      @(posedge hclk);
      n0 += (stg[1:0] != 2'h0);
      n1 += (stg[3:2] != 2'h0);
    end
    check(n0, WS);
    check(n1, WS / 2);
  endtask
  // Main sequence; temperature cases wait out wake-up blanking first.
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    wake_up = 1'b0;
    pwm_in = 4'h0;
    ssd = 4'h0;
    load_a = 8'h0a;
    temp_c = 32'h1e1e_1e1e;
    die_c = 8'h20;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    wake_up <= 1'b1;
    @(posedge hclk);
    wake_up <= 1'b0;
    bus(1'b0, ADDR_CONFIG, 32'h0);
    check(rd, 32'h0000_0000);
    bus(1'b0, 8'h24, 32'h0);
    check(rd, 32'h0000_0000);
    die_c <= 8'h50;
    bus(1'b1, ADDR_CONFIG, 32'h0000_0001);
    repeat (6) @(posedge hclk);
    check(ldr, 1'b1);
    die_c <= 8'h20;
    repeat (6) @(posedge hclk);
    check(ldr, 1'b0);
    bus(1'b1, ADDR_CONFIG, 32'h0000_0000);
    win_run();
    bus(1'b1, ADDR_CHANNEL, 32'h0000_0000);
    win_run();
    bus(1'b1, ADDR_CHANNEL, 32'h0000_0000);
    bus(1'b1, ADDR_CONFIG, 32'h0000_0012);
    bus(1'b1, ADDR_CHANNEL, 32'h0000_0001);
    repeat (200) @(posedge hclk);
    check(stg[1:0], 2'h1);
    check(hs[0], 1'b0);
    pwm_in <= 4'hf;
    repeat (3) @(posedge hclk);
    check(hs[0], 1'b1);
    repeat (200) @(posedge hclk);
    check(stg[1:0], 2'h0);
    check(hs[0], 1'b0);
    bus(1'b1, ADDR_CONFIG, 32'h0000_0000);
    bus(1'b1, ADDR_CHANNEL, 32'h0000_0004);
    temp_c <= 32'h1e78_1e1e;
    repeat (2800) @(posedge hclk);
    bus(1'b0, ADDR_QUICK, 32'h0);
    check(rd, 32'h0000_4000);
    bus(1'b1, ADDR_CONFIG, 32'h0000_0004);
    repeat (120) @(posedge hclk);
    bus(1'b0, ADDR_QUICK, 32'h0);
    check(rd, 32'h0000_4400);
    bus(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0000_0041);
    bus(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0000_0041);
    temp_c <= 32'h1e64_1e1e;
    repeat (120) @(posedge hclk);
    bus(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0000_0041);
    bus(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0000_0040);
    bus(1'b1, ADDR_IRQ_MASK, 32'h0000_0040);
    temp_c <= 32'h1eb4_1e1e;
    repeat (120) @(posedge hclk);
    check(oe, 4'h0);
    check(irq, 1'b1);
    bus(1'b0, ADDR_QUICK, 32'h0);
    check(rd, 32'h0000_0440);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h0000_0040);
    @(posedge hclk);
    check(irq, 1'b0);
    // Fail mode: a short severe-short glitch is filtered out, a lasting overcurrent restarts.
    bus(1'b1, ADDR_CONFIG, 32'h0000_0008);
    bus(1'b1, ADDR_CHANNEL, 32'h0000_0001);
    ssd <= 4'h1;
    repeat (50) @(posedge hclk);
    ssd <= 4'h0;
    repeat (120) @(posedge hclk);
    check(oe[0], 1'b1);
    load_a <= 8'h78;
    repeat (120) @(posedge hclk);
    check(oe[0], 1'b0);
    load_a <= 8'h0a;
    repeat (200) @(posedge hclk);
    check(oe[0], 1'b1);
    stop_test();
  end
endmodule
bind prt_sequencer prt_seq_asserts u_chk(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .wake_up(wake_up),
  .die_hot(die_hot), .vout_half(vout_half), .inrush_stage(inrush_stage), .half_scale(half_scale),
  .level_one_reduced(level_one_reduced));
